//--- hdl/cap_consts.svh
// register offsets, field positions, reset values and divider counts
`ifndef CAP_CONSTS_SVH
`define CAP_CONSTS_SVH

`define CAP_AW 8
`define CAP_ADDR_CTRL 8'h00
`define CAP_ADDR_CMODE 8'h04
`define CAP_ADDR_CNTL 8'h08
`define CAP_ADDR_CNTH 8'h0C
`define CAP_ADDR_MMODE0 8'h10
`define CAP_ADDR_CPL0 8'h20
`define CAP_MMODE_STEP 8'h04
`define CAP_CP_STEP 8'h08
`define CAP_CPH_OFS 8'h04

// control register fields
`define CAP_CTRL_CF 7
`define CAP_CTRL_CR 6
// counter mode register fields
`define CAP_CMODE_IDLE_SUSPEND_BIT 7
`define CAP_CMODE_WATCHDOG_ENABLE_BIT 6
`define CAP_CMODE_CPS_HI 3
`define CAP_CMODE_CPS_LO 1
`define CAP_CMODE_ECF 0
// module mode register fields
`define CAP_MM_WIDE 7
`define CAP_MM_ECOM 6
`define CAP_MM_MAT 3
`define CAP_MM_TOG 2
`define CAP_MM_PWM 1
`define CAP_MM_EIRQ 0
`define CAP_MM_WDT_FORCE 8'h48

// counter clock selections
`define CAP_CPS_DIV12 3'h0
`define CAP_CPS_DIV4 3'h1
`define CAP_CPS_TMR 3'h2
`define CAP_CPS_EXT8 3'h3
`define CAP_CPS_SYS 3'h4
`define CAP_TC_DIV12 4'hB
`define CAP_TC_DIV4 4'h3
`define CAP_TC_EXT8 4'h7

`define CAP_WATCHDOG_ENABLE_BIT_RST 1'b1
`define CAP_BYTE_MAX 8'hFF
`define CAP_WORD_MAX 16'hFFFF
`define CAP_CNT_ONE 16'h0001

`endif

//--- hdl/cap_pkg.sv
// types shared by the counter array and its bench
package cap_pkg;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cap_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cap_apb_rsp_t;

	typedef enum logic [5:0] {
		CAP_M_OFF = 6'b000001,
		CAP_M_TIMER = 6'b000010,
		CAP_M_HSO = 6'b000100,
		CAP_M_FREQ = 6'b001000,
		CAP_M_PWM8 = 6'b010000,
		CAP_M_PWM16 = 6'b100000
	} cap_mode_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic cf;
		logic cr;
		logic [2:0] ccf;
		logic idle_suspend_bit;
		logic watchdog_enable_bit;
		logic [2:0] cps;
		logic ecf;
		logic [2:0][7:0] mode;
		logic [2:0][7:0] cpl;
		logic [2:0][7:0] cph;
		logic [2:0] pin;
		logic [3:0] div;
		logic [2:0] ext_sync;
		logic wdt_rst;
		logic [31:0] rdata;
	} cap_state_t;

endpackage

//--- hdl/cap_counter_array.sv
// counter array with compare, pwm, frequency output and watchdog modules
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "cap_consts.svh"

module cap_counter_array (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register bus
	input wire cap_pkg::cap_apb_req_t apb_req,
	output cap_pkg::cap_apb_rsp_t apb_rsp,
	// counter clock sources and idle state
	input wire logic timer_tick,
	input wire logic ext_clk_pin,
	input wire logic cpu_idle,
	// module pins, interrupt and watchdog
	output logic [2:0] module_io_pin,
	output logic irq_req,
	output logic wdt_reset_req
);
	import cap_pkg::*;

	cap_state_t st_reg;
	cap_state_t st_next;
	logic [1:0] rst_sync_reg;
	logic rst_n;
	logic tick;
	logic tick_en;
	logic adv;
	logic acc;
	logic wr;
	logic lo_ovf;
	logic hi_ovf;
	logic fire;
	logic ecom;
	logic mat;
	logic m16;
	logic m8;
	logic [7:0] cmp8;
	logic [7:0] mreg;
	logic [7:0] wb;
	logic [15:0] cnt_inc;
	logic [2:0] ccf_set;
	logic [2:0] eirq;
	cap_mode_t md;

	// mode decode: pwm bits outrank toggle and match, so the widest
	// pwm or frequency mode wins over timer and toggle when software leaves stray bits set
	function automatic cap_mode_t mode_of(input logic [7:0] m);
		if (m[`CAP_MM_PWM] && m[`CAP_MM_WIDE])
			return CAP_M_PWM16;
		else if (m[`CAP_MM_PWM] && m[`CAP_MM_TOG])
			return CAP_M_FREQ;
		else if (m[`CAP_MM_PWM])
			return CAP_M_PWM8;
		else if (m[`CAP_MM_TOG] && m[`CAP_MM_MAT])
			return CAP_M_HSO;
		else if (m[`CAP_MM_MAT])
			return CAP_M_TIMER;
		else
			return CAP_M_OFF;
	endfunction

	// register map helpers: each register owns one aligned word and the
	// three modules repeat at a fixed stride
	function automatic logic [7:0] mmode_addr(input int i);
		return 8'(`CAP_ADDR_MMODE0 + i * `CAP_MMODE_STEP);
	endfunction

	function automatic logic [7:0] cpl_addr(input int i);
		return 8'(`CAP_ADDR_CPL0 + i * `CAP_CP_STEP);
	endfunction

	function automatic logic [7:0] cph_addr(input int i);
		return 8'(`CAP_ADDR_CPL0 + `CAP_CPH_OFS + i * `CAP_CP_STEP);
	endfunction

	// offsets outside the map answer with an error and change nothing
	function automatic logic mapped(input logic [7:0] a);
		logic hit;
		hit = (a == `CAP_ADDR_CTRL) || (a == `CAP_ADDR_CMODE) ||
			(a == `CAP_ADDR_CNTL) || (a == `CAP_ADDR_CNTH);
		for (int i = 0; i < 3; i++) begin
			hit = hit || (a == mmode_addr(i)) || (a == cpl_addr(i)) ||
				(a == cph_addr(i));
		end
		return hit;
	endfunction

	// reads see registered state, never the byte being written in the
	// same cycle
	function automatic logic [7:0] rd_byte(input cap_state_t s,
		input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			`CAP_ADDR_CTRL: v = {s.cf, s.cr, 3'h0, s.ccf};
			`CAP_ADDR_CMODE: v = {s.idle_suspend_bit, s.watchdog_enable_bit, 2'h0, s.cps, s.ecf};
			`CAP_ADDR_CNTL: v = s.cnt[7:0];
			`CAP_ADDR_CNTH: v = s.cnt[15:8];
			default: begin
				for (int i = 0; i < 3; i++) begin
					if (a == mmode_addr(i))
						v = s.mode[i];
					if (a == cpl_addr(i))
						v = s.cpl[i];
					if (a == cph_addr(i))
						v = s.cph[i];
				end
			end
		endcase
		return v;
	endfunction

	// terminal count of the prescaler; selections without a divider
	// never reach it, so they fall back to twelve harmlessly
	function automatic logic [3:0] term_count(input logic [2:0] c);
		case (c)
			`CAP_CPS_DIV4: return `CAP_TC_DIV4;
			`CAP_CPS_EXT8: return `CAP_TC_EXT8;
			default: return `CAP_TC_DIV12;
		endcase
	endfunction

	// a watchdog pulse does not reach here; the system reset comes back
	// through rst_b
	// reset enters asynchronously, is released through two flops
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// zero wait states: every access phase completes in its first cycle
	assign acc = apb_req.psel && apb_req.penable;
	assign wr = acc && apb_req.pwrite && mapped(apb_req.paddr);
	assign wb = apb_req.pwdata[7:0];

	always_comb begin
		st_next = st_reg;
		tick = 1'b0;
		adv = 1'b0;
		fire = 1'b0;
		ccf_set = 3'h0;
		ecom = 1'b0;
		mat = 1'b0;
		m16 = 1'b0;
		m8 = 1'b0;
		cmp8 = 8'h00;
		mreg = 8'h00;
		md = CAP_M_OFF;

		// counter clock: the prescaler makes one-cycle enable pulses, so
		// everything stays on the one system clock

		// external clock pin: three flops, edge found on the later pair
		st_next.ext_sync = {st_reg.ext_sync[1:0], ext_clk_pin};
		case (st_reg.cps)
			`CAP_CPS_DIV12, `CAP_CPS_DIV4, `CAP_CPS_EXT8: begin
				adv = (st_reg.cps == `CAP_CPS_EXT8) ?
					(st_reg.ext_sync[1] && !st_reg.ext_sync[2]) : 1'b1;
				if (adv) begin
					if (st_reg.div == term_count(st_reg.cps)) begin
						st_next.div = 4'h0;
						tick = 1'b1;
					end else begin
						st_next.div = st_reg.div + 4'h1;
					end
				end
			end
			`CAP_CPS_TMR: tick = timer_tick;
			`CAP_CPS_SYS: tick = 1'b1;
			default: tick = 1'b0;
		endcase


		// the watchdog keeps the counter running whatever the run bit says
		tick_en = tick && (st_reg.cr || st_reg.watchdog_enable_bit) &&
			!(st_reg.idle_suspend_bit && cpu_idle);
		cnt_inc = st_reg.cnt + `CAP_CNT_ONE;
		lo_ovf = tick_en && (st_reg.cnt[7:0] == `CAP_BYTE_MAX);
		hi_ovf = tick_en && (st_reg.cnt == `CAP_WORD_MAX);
		if (tick_en)
			st_next.cnt = cnt_inc;


		// per-module compare: match events fire on the tick that makes
		// the counter equal the compare value, not a cycle later
		for (int i = 0; i < 3; i++) begin
			mreg = st_reg.mode[i];
			if (i == 2 && st_reg.watchdog_enable_bit)
				mreg = `CAP_MM_WDT_FORCE;
			md = mode_of(mreg);
			ecom = mreg[`CAP_MM_ECOM];
			mat = mreg[`CAP_MM_MAT];
			// the low byte reloads at wrap, so compare against the new one
			cmp8 = (lo_ovf && md == CAP_M_PWM8) ? st_reg.cph[i] :
				st_reg.cpl[i];
			m16 = tick_en && (cnt_inc == {st_reg.cph[i], st_reg.cpl[i]});
			m8 = tick_en && (cnt_inc[7:0] == cmp8);
			case (md)
				CAP_M_TIMER: begin
					if (ecom && m16)
						ccf_set[i] = 1'b1;
				end

				CAP_M_HSO: begin
					if (ecom && m16) begin
						st_next.pin[i] = !st_reg.pin[i];
						ccf_set[i] = 1'b1;
					end
				end

				// the sum wraps in eight bits: a zero step gives 256 counts
				CAP_M_FREQ: begin
					if (ecom && m8) begin
						st_next.pin[i] = !st_reg.pin[i];
						st_next.cpl[i] = 8'(st_reg.cpl[i] + st_reg.cph[i]);
					end
					if (ecom && mat && m16)
						ccf_set[i] = 1'b1;
				end

				// reload and clear share the low byte wrap
				CAP_M_PWM8: begin
					if (lo_ovf) begin
						st_next.cpl[i] = st_reg.cph[i];
						st_next.pin[i] = 1'b0;
					end
					// set beats clear so a zero high byte gives full duty
					if (ecom && m8) begin
						st_next.pin[i] = 1'b1;
						ccf_set[i] = mat;
					end
					if (!ecom)
						st_next.pin[i] = 1'b0;
				end

				CAP_M_PWM16: begin
					if (hi_ovf)
						st_next.pin[i] = 1'b0;
					if (ecom && m16) begin
						st_next.pin[i] = 1'b1;
						ccf_set[i] = mat;
					end
					if (!ecom)
						st_next.pin[i] = 1'b0;
				end

				// modes without a compare path leave pin and flag alone
				default: ;
			endcase
		end

		// watchdog expires on low wrap while its byte equals counter high
		if (st_reg.watchdog_enable_bit && lo_ovf && st_reg.cph[2] == st_reg.cnt[15:8])
			fire = 1'b1;

		// writes follow the tick logic, so software wins over a same-cycle tick except for the flags set below
		if (wr) begin
			case (apb_req.paddr)
				`CAP_ADDR_CTRL: begin
					st_next.cf = wb[`CAP_CTRL_CF];
					st_next.cr = wb[`CAP_CTRL_CR];
					st_next.ccf = wb[2:0];
					if (st_reg.watchdog_enable_bit && wb[2])
						fire = 1'b1;
				end

				// clock select and idle bit are frozen while the watchdog runs
				`CAP_ADDR_CMODE: begin
					st_next.watchdog_enable_bit = wb[`CAP_CMODE_WATCHDOG_ENABLE_BIT];
					st_next.ecf = wb[`CAP_CMODE_ECF];
					if (!st_reg.watchdog_enable_bit) begin
						st_next.idle_suspend_bit = wb[`CAP_CMODE_IDLE_SUSPEND_BIT];
						st_next.cps = wb[`CAP_CMODE_CPS_HI:`CAP_CMODE_CPS_LO];
					end
				end

				// counter bytes are locked while the watchdog owns the counter
				`CAP_ADDR_CNTL: begin
					if (!st_reg.watchdog_enable_bit)
						st_next.cnt[7:0] = wb;
				end
				`CAP_ADDR_CNTH: begin
					if (!st_reg.watchdog_enable_bit)
						st_next.cnt[15:8] = wb;
				end

				// module registers; module 2 mode is locked under the watchdog
				default: begin
					for (int i = 0; i < 3; i++) begin
						if (apb_req.paddr == mmode_addr(i) &&
							!(i == 2 && st_reg.watchdog_enable_bit))
							st_next.mode[i] = wb;
						if (apb_req.paddr == cpl_addr(i)) begin
							st_next.cpl[i] = wb;
							st_next.mode[i][`CAP_MM_ECOM] = 1'b0;
						end
						if (apb_req.paddr == cph_addr(i)) begin
							if (i == 2 && st_reg.watchdog_enable_bit) begin
								// the refresh wraps in eight bits like the counter
								st_next.cph[i] = 8'(st_reg.cnt[15:8] +
									st_reg.cpl[2]);
							end else begin
								st_next.cph[i] = wb;
								st_next.mode[i][`CAP_MM_ECOM] = 1'b1;
							end
						end
					end
				end
			endcase
		end

		// hardware sets win over a software clear in the same cycle
		st_next.ccf = st_next.ccf | ccf_set;
		if (hi_ovf)
			st_next.cf = 1'b1;
		st_next.wdt_rst = fire;

		// read data is captured in the setup cycle, shown in the access
		if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
			st_next.rdata = {24'h0, rd_byte(st_reg, apb_req.paddr)};
	end

	// the whole state is one register; only constants load on reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.watchdog_enable_bit <= `CAP_WATCHDOG_ENABLE_BIT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// interrupt enables sit in bit zero of each module mode register
	always_comb begin
		for (int i = 0; i < 3; i++)
			eirq[i] = st_reg.mode[i][`CAP_MM_EIRQ];
	end

	// a level: it falls only when software clears the flag or its enable
	assign irq_req = |(st_reg.ccf & eirq) ||
		(st_reg.cf && st_reg.ecf);
	assign module_io_pin = st_reg.pin;
	assign wdt_reset_req = st_reg.wdt_rst;
	assign apb_rsp.prdata = st_reg.rdata;
	assign apb_rsp.pready = acc;
	assign apb_rsp.pslverr = acc && !mapped(apb_req.paddr);
endmodule

//--- tb/cap_counter_array_asserts.sv
// port checker for the counter array
`timescale 1ns/1ps
module cap_counter_array_asserts (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// register bus
	input wire cap_pkg::cap_apb_req_t apb_req,
	input wire cap_pkg::cap_apb_rsp_t apb_rsp,
	// pins and requests
	input wire logic [2:0] module_io_pin,
	input wire logic irq_req,
	input wire logic wdt_reset_req
);
	import cap_pkg::*;
	logic acc;
	logic wr;
	logic wd_on;
	assign acc = apb_req.psel & apb_req.penable;
	assign wr = acc & apb_req.pwrite;
	// mirror of the watchdog enable; every reset turns it back on
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			wd_on <= 1'b1;
		else if (wr && apb_req.paddr == 8'h04)
			wd_on <= apb_req.pwdata[6];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	AST_READY: assert property (apb_rsp.pready == acc)
		else $error("pready not in access phase");
	AST_UNMAPPED: assert property (acc && apb_req.paddr == 8'hFC
		|-> apb_rsp.pslverr) else $error("no error on unmapped");
	AST_MAPPED: assert property (acc && apb_req.paddr == 8'h00
		|-> !apb_rsp.pslverr) else $error("error on control");
	AST_UPPER: assert property (acc |-> apb_rsp.prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_PULSE: assert property (wdt_reset_req |=> !wdt_reset_req)
		else $error("watchdog pulse too long");
	AST_FORCE: assert property (wr && apb_req.paddr == 8'h00 &&
		apb_req.pwdata[2] && wd_on |=> wdt_reset_req)
		else $error("forced watchdog reset missing");
	AST_OFF: assert property (!wd_on |=> !wdt_reset_req)
		else $error("watchdog reset while disabled");
	AST_PWM_OFF: assert property (wr && apb_req.paddr == 8'h14 &&
		apb_req.pwdata[7:0] == 8'h02 |-> ##2 !module_io_pin[1])
		else $error("pwm pin high with comparator off");
	COV_FORCE: cover property (wr && apb_req.paddr == 8'h00 && wd_on);
	COV_ERR: cover property (apb_rsp.pslverr);
	COV_IRQ: cover property ($rose(irq_req));
endmodule

bind cap_counter_array cap_counter_array_asserts u_chk (
	.clock(clock), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.module_io_pin(module_io_pin), .irq_req(irq_req),
	.wdt_reset_req(wdt_reset_req));

//--- tb/cap_pin_partner.sv
// clock sources and idle level seen by the counter array
`timescale 1ns/1ps
module cap_pin_partner (
	// clock
	input wire logic clock,
	// sources
	output logic timer_tick,
	output logic ext_clk_pin,
	output logic cpu_idle
);
	logic [7:0] cnt = 8'h00;
	always @(posedge clock)
		cnt <= cnt + 8'h01;
	// each level lasts two system clocks; a level of one system clock is still seen
	assign ext_clk_pin = cnt[1];
	assign timer_tick = (cnt[2:0] == 3'h7);
	assign cpu_idle = 1'b0;
endmodule

//--- tb/cap_counter_array_tb.sv
// self-checking bench for the counter array
`timescale 1ns/1ps
module cap_counter_array_tb;
	import cap_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	cap_apb_req_t req = '0;
	cap_apb_rsp_t rsp;
	logic tick, ext_pin, idle, irq, wdt;
	logic [2:0] pins;
	logic [32:0] expq[$];
	logic [31:0] seed = 32'hE9F0;
	int n_mismatch = 0;
	int samples_checked = 0;
	int n;

	always #4 clock = ~clock;

	cap_pin_partner u_pin (.clock(clock), .timer_tick(tick),
		.ext_clk_pin(ext_pin), .cpu_idle(idle));
	cap_counter_array u_dut (.clock(clock), .rst_b(rst_b), .apb_req(req),
		.apb_rsp(rsp), .timer_tick(tick), .ext_clk_pin(ext_pin),
		.cpu_idle(idle), .module_io_pin(pins), .irq_req(irq),
		.wdt_reset_req(wdt));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clock);
		req <= '{1'b1, 1'b0, w, a, {24'h000000, d}};
		@(posedge clock);
		req.penable <= 1'b1;
		@(posedge clock);
		while (rsp.pready !== 1'b1)
			@(posedge clock);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// the monitor below compares the read data with this note
	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		expq.push_back(exp);
		apb(1'b0, a, 8'h00);
	endtask
	task automatic reset_dut();
		rst_b <= 1'b0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
	endtask
	task automatic duty(input logic [32:0] exp);
		repeat (512) @(negedge clock);
		n = 0;
		repeat (256) begin
			@(negedge clock);
			n += pins[1];
		end
		check(33'(n), exp);
	endtask
	task automatic wait_wdt(input int lim);
		n = 0;
		while (wdt !== 1'b1 && n < 400) begin
			@(negedge clock);
			n++;
		end
		check({32'h0, n <= lim}, 33'h1);
	endtask

	always @(posedge clock)
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1)
			check({rsp.pslverr, rsp.prdata}, expq.pop_front());

	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		stop_test();
	end

	initial begin
		logic [7:0] v;
		reset_dut();
		rd(8'h04, 33'h40);
		rd(8'h30, 33'h0);
		rd(8'hFC, {1'b1, 32'h0});
		// clock select is frozen until the watchdog is off
		apb(1'b1, 8'h04, 8'h00);
		apb(1'b1, 8'h04, 8'h08);
		rd(8'h04, 33'h08);
		apb(1'b1, 8'h08, 8'h00);
		apb(1'b1, 8'h0C, 8'h00);
		apb(1'b1, 8'h10, 8'h49);
		apb(1'b1, 8'h20, 8'h10);
		rd(8'h10, 33'h09);
		apb(1'b1, 8'h24, 8'h00);
		rd(8'h10, 33'h49);
		apb(1'b1, 8'h00, 8'h40);
		repeat (40) @(negedge clock);
		rd(8'h00, 33'h41);
		check({32'h0, irq}, 33'h1);
		repeat (20) @(negedge clock);
		rd(8'h00, 33'h41);
		apb(1'b1, 8'h00, 8'h40);
		rd(8'h00, 33'h40);
		check({32'h0, irq}, 33'h0);
		apb(1'b1, 8'h14, 8'h02);
		seed = xs(seed);
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
			apb(1'b1, 8'h2C, v);
			duty(33'h100 - 33'(v));
		end
		apb(1'b1, 8'h14, 8'h02);
		duty(33'h0);
		apb(1'b1, 8'h04, 8'h48);
		apb(1'b1, 8'h34, 8'h00);
		// refresh leaves at most one low byte wrap plus the pulse latency
		wait_wdt(258);
		reset_dut();
		rd(8'h04, 33'h40);
		apb(1'b1, 8'h00, 8'h04);
		wait_wdt(3);
		stop_test();
	end
endmodule
